// File: design/imc_pkg.sv
// Shared constants and types for the inertial unit control register bank
package imc_pkg;

    // Byte addresses on the serial register port
    localparam logic [6:0] RANGE_ID_ADDR = 7'h5E;
    localparam logic [6:0] MISC_CTRL_LO_ADDR = 7'h60;
    localparam logic [6:0] MISC_CTRL_HI_ADDR = 7'h61;

    // Control register reset value and bit layout
    localparam logic [15:0] MISC_CTRL_RESET = 16'h00C1;
    localparam logic [15:0] MISC_CTRL_MASK = 16'h03DF;
    localparam logic [15:0] FAST_BITS_MASK = 16'h03C3;
    localparam logic [15:0] SLOW_BITS_MASK = 16'h001C;
    localparam int BIT_BURST_WIDE = 9;
    localparam int BIT_BURST_DELTA = 8;
    localparam int BIT_LIN_COMP = 7;
    localparam int BIT_POP_ALIGN = 6;
    localparam int BIT_BANDWIDTH = 4;
    localparam int SYNC_MODE_LSB = 2;
    localparam int BIT_SYNC_POL = 1;
    localparam int BIT_DR_POL = 0;

    // Range identifier fixed low bits and default range code
    localparam logic [1:0] RANGE_FIXED_BITS = 2'h3;
    localparam logic [1:0] RANGE_CODE_RESET = 2'h0;

    // Sample-synchronisation modes
    typedef enum logic [1:0] {
        IMC_SYNC_INTERNAL = 2'b00,
        IMC_SYNC_DIRECT = 2'b01,
        IMC_SYNC_SCALED = 2'b10,
        IMC_SYNC_OUTPUT = 2'b11
    } imc_sync_mode_t;

    // Timing; cycle counts derived from the reference clock rate
    localparam int CLK_FREQ_MHZ = 100;
    localparam int APPLY_TIME_US = 200;
    localparam int APPLY_CYCLES = APPLY_TIME_US * CLK_FREQ_MHZ;
    localparam int REINIT_TIME_MS = 250;
    localparam int REINIT_CYCLES = REINIT_TIME_MS * 1000 * CLK_FREQ_MHZ;
    localparam int INT_SAMPLE_HZ = 2000;
    localparam int INT_SAMPLE_CYCLES = CLK_FREQ_MHZ * 1000000 / INT_SAMPLE_HZ;
    localparam int DR_PULSE_TIME_NS = 1000;
    localparam int DR_PULSE_CYCLES = DR_PULSE_TIME_NS * CLK_FREQ_MHZ / 1000;
    localparam logic [15:0] UPSCALE_RESET = 16'h07D0;
    localparam int SPI_FRAME_BITS = 16;

endpackage : imc_pkg

// File: design/imc_serial_port.sv
// Serial register port: 16-bit frames, write or read request per frame
`timescale 1ns/100ps
module imc_serial_port (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic [15:0] i_rd_word,
    output logic o_miso,
    output logic o_wr_stb,
    output logic [6:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [6:0] o_rd_addr
);

    typedef struct packed {
        logic sclk_prev;
        logic cs_n_prev;
        logic [3:0] bit_cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic wr_stb;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic [6:0] rd_addr;
    } imc_spi_state_t;

    imc_spi_state_t s_reg;
    imc_spi_state_t s_next;

    // Clock idles high; input taken on rising edge, output moved on falling edge
    always_comb begin
        logic [15:0] rx_shift;
        rx_shift = {s_reg.rx[14:0], i_mosi};
        s_next = s_reg;
        s_next.wr_stb = 1'b0;
        s_next.sclk_prev = i_sclk;
        s_next.cs_n_prev = i_cs_n;
        if (i_cs_n) begin
            s_next.bit_cnt = 4'h0;
        end else if (s_reg.cs_n_prev) begin
            // Answer to the previous frame's read address
            s_next.tx = i_rd_word;
        end else if (!s_reg.sclk_prev && i_sclk) begin
            s_next.rx = rx_shift;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            if (s_reg.bit_cnt == 4'(imc_pkg::SPI_FRAME_BITS - 1)) begin
                if (rx_shift[15]) begin
                    s_next.wr_stb = 1'b1;
                    s_next.wr_addr = rx_shift[14:8];
                    s_next.wr_data = rx_shift[7:0];
                end else begin
                    s_next.rd_addr = rx_shift[14:8];
                end
            end
        end else if (s_reg.sclk_prev && !i_sclk && s_reg.bit_cnt != 4'h0) begin
            s_next.tx = {s_reg.tx[14:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.sclk_prev <= 1'b1;
            s_reg.cs_n_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_miso = s_reg.tx[15];
    assign o_wr_stb = s_reg.wr_stb;
    assign o_wr_addr = s_reg.wr_addr;
    assign o_wr_data = s_reg.wr_data;
    assign o_rd_addr = s_reg.rd_addr;

endmodule : imc_serial_port

// File: design/imc_sync_scaler.sv
// Sync pin edge detector and rate multiplier for scaled sync mode
`timescale 1ns/100ps
module imc_sync_scaler (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sync,
    input wire logic i_rise_sel,
    input wire logic [15:0] i_scale,
    output logic o_edge,
    output logic o_tick
);

    typedef struct packed {
        logic sync_prev;
        logic [31:0] period_cnt;
        logic [31:0] period;
        logic [31:0] acc;
        logic edge_seen;
        logic tick;
    } imc_scaler_state_t;

    imc_scaler_state_t s_reg;
    imc_scaler_state_t s_next;

    // Phase accumulator emits i_scale ticks per measured input period
    always_comb begin
        logic active_edge;
        logic [31:0] sum;
        active_edge = i_rise_sel ? (!s_reg.sync_prev && i_sync) : (s_reg.sync_prev && !i_sync);
        sum = s_reg.acc + {16'h0000, i_scale};
        s_next = s_reg;
        s_next.sync_prev = i_sync;
        s_next.edge_seen = active_edge;
        s_next.tick = 1'b0;
        if (s_reg.period_cnt != 32'hFFFF_FFFF) begin
            s_next.period_cnt = s_reg.period_cnt + 32'h0000_0001;
        end
        if (active_edge) begin
            s_next.period = s_reg.period_cnt + 32'h0000_0001;
            s_next.period_cnt = 32'h0000_0000;
            s_next.acc = 32'h0000_0000;
            // The edge is itself a sample instant, else only K-1 ticks fit
            s_next.tick = (s_reg.period != 32'h0000_0000);
        end else if (s_reg.period != 32'h0000_0000) begin
            if (sum >= s_reg.period) begin
                s_next.tick = 1'b1;
                s_next.acc = sum - s_reg.period;
            end else begin
                s_next.acc = sum;
            end
        end
    end

    // Until the first edge is seen the period is zero and no tick is made
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_edge = s_reg.edge_seen;
    assign o_tick = s_reg.tick;

endmodule : imc_sync_scaler

// File: design/imc_misc_control.sv
// Range identifier and miscellaneous control register bank with sample timing
//
// How it works
// R1 - Range identifier shows gyro range code in bits 3:2, bits 1:0 read 11.
// R2 - Host writes zero to control bit 5, which is unused.
// R3 - Control bit 9 selects 32-bit burst words when one, 16-bit when zero.
// R4 - New burst type takes effect only after a full data-ready cycle.
// R5 - Control bit 8 selects delta data in burst when one, raw when zero.
// R6 - Bits 9,8,7,6,1,0 may take up to 200 us before readback shows them.
// R7 - Control bit 7 enables linear-acceleration compensation of gyro outputs.
// R8 - Control bit 6 enables relocating accelerometers to the package corner.
// R9 - Changing bandwidth bit 4 reinitialises sensors for up to 250 ms.
// R10 - Bandwidth bit zero means wide bandwidth, one means 370 Hz.
// R11 - Sync code 00 samples from the internal 2 kHz clock.
// R12 - Sync code 01 samples directly on edges of an external sync clock.
// R13 - Sync code 10 multiplies a slow external sync clock up to sample rate.
// R14 - Sync code 11 samples internally and drives sample instants on sync pin.
// R15 - Host may write sync mode and upscale together, then wait for data ready.
// R16 - Control bit 1 picks the sync active edge, one rising, zero falling.
// R17 - Control bit 0 sets data-ready polarity, one active high, zero low.
// R18 - Control bits 15 to 10 ignore writes and read back as zero.
`timescale 1ns/100ps
module imc_misc_control #(
    parameter int APPLY_CYCLES = imc_pkg::APPLY_CYCLES,
    parameter int REINIT_CYCLES = imc_pkg::REINIT_CYCLES,
    parameter int INT_SAMPLE_CYCLES = imc_pkg::INT_SAMPLE_CYCLES,
    parameter logic [15:0] UPSCALE_FACTOR = imc_pkg::UPSCALE_RESET,
    parameter logic [1:0] GYRO_RANGE_CODE = imc_pkg::RANGE_CODE_RESET
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_MOSI,
    input wire logic I_SYNC,
    output logic O_MISO,
    output logic O_SYNC,
    output logic O_SYNC_OE,
    output logic O_SAMPLE_VALID_STROBE,
    output logic O_SAMPLE_TICK,
    output logic O_BURST_WIDE_WORDS,
    output logic O_BURST_DELTA_SEL,
    output logic O_LIN_ACCEL_COMP_EN,
    output logic O_POP_ALIGN_EN,
    output logic O_SENSOR_BANDWIDTH_SELECT,
    output logic O_SENSOR_REINIT,
    output logic [1:0] O_SYNC_MODE
);

    // Apply sequencer: running, waiting out readback delay, reinitialising
    typedef enum logic [1:0] {
        IMC_PH_RUN = 2'b00,
        IMC_PH_APPLY = 2'b01,
        IMC_PH_REINIT = 2'b10
    } imc_phase_t;

    typedef struct packed {
        imc_phase_t phase;
        logic [15:0] misc_control;
        logic [15:0] written;
        logic [31:0] timer;
        logic rearm;
        logic [31:0] int_cnt;
        logic [15:0] pulse_cnt;
        logic sample_tick;
        logic dr_pin;
        logic sync_out;
        logic sync_oe;
        logic burst_wide;
        logic burst_delta;
    } imc_state_t;

    imc_state_t s_reg;
    imc_state_t s_next;

    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [15:0] rd_word;
    logic ext_edge;
    logic scaled_tick;
    logic [1:0] shown_mode;

    assign shown_mode = s_reg.misc_control[imc_pkg::SYNC_MODE_LSB +: 2];

    // Serial register port
    imc_serial_port u_port (
        .i_clk(I_REF_CLK),
        .i_rst(I_RESET),
        .i_sclk(I_SCLK),
        .i_cs_n(I_CS_N),
        .i_mosi(I_MOSI),
        .i_rd_word(rd_word),
        .o_miso(O_MISO),
        .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_rd_addr(rd_addr)
    );

    // External sync edge detection and rate multiplication
    imc_sync_scaler u_scaler (
        .i_clk(I_REF_CLK),
        .i_rst(I_RESET),
        .i_sync(I_SYNC),
        .i_rise_sel(s_reg.misc_control[imc_pkg::BIT_SYNC_POL]), // [R16]
        .i_scale(UPSCALE_FACTOR), // [R13]
        .o_edge(ext_edge),
        .o_tick(scaled_tick)
    );

    // Read data; odd byte addresses return the word of their even partner
    always_comb begin
        if ({rd_addr[6:1], 1'b0} == imc_pkg::RANGE_ID_ADDR) begin
            rd_word = {12'h000, GYRO_RANGE_CODE, imc_pkg::RANGE_FIXED_BITS}; // [R1]
        end else if ({rd_addr[6:1], 1'b0} == imc_pkg::MISC_CTRL_LO_ADDR) begin
            rd_word = s_reg.misc_control;
        end else begin
            rd_word = 16'h0000;
        end
    end

    // Next state of the whole bank
    always_comb begin
        logic [15:0] wr_val;
        logic tick;
        logic active;
        logic sync_pol;
        logic dr_pol;
        wr_val = s_reg.written;
        tick = 1'b0;
        active = 1'b0;
        sync_pol = s_reg.misc_control[imc_pkg::BIT_SYNC_POL];
        dr_pol = s_reg.misc_control[imc_pkg::BIT_DR_POL];
        s_next = s_reg;

        // Register writes land in a shadow copy; unused bits are dropped
        if (wr_stb && wr_addr == imc_pkg::MISC_CTRL_LO_ADDR) begin
            wr_val[7:0] = wr_data & imc_pkg::MISC_CTRL_MASK[7:0]; // [R2]
        end
        if (wr_stb && wr_addr == imc_pkg::MISC_CTRL_HI_ADDR) begin
            wr_val[15:8] = wr_data & imc_pkg::MISC_CTRL_MASK[15:8]; // [R18]
        end
        s_next.written = wr_val;

        // Sequencer: fast bits after the apply delay, slow bits after reinit
        unique case (s_reg.phase)
            IMC_PH_RUN: begin
                if (wr_stb) begin
                    s_next.phase = IMC_PH_APPLY;
                    s_next.timer = 32'(APPLY_CYCLES - 1); // [R6]
                end
            end
            IMC_PH_APPLY: begin
                if (wr_stb) begin
                    // A further write restarts the wait so both bytes go together
                    s_next.timer = 32'(APPLY_CYCLES - 1); // [R6]
                end else if (s_reg.timer != 32'h0000_0000) begin
                    s_next.timer = s_reg.timer - 32'h0000_0001;
                end else begin
                    s_next.misc_control = (s_reg.misc_control & ~imc_pkg::FAST_BITS_MASK)
                        | (s_reg.written & imc_pkg::FAST_BITS_MASK); // [R6]
                    if ((s_reg.written & imc_pkg::SLOW_BITS_MASK)
                            != (s_reg.misc_control & imc_pkg::SLOW_BITS_MASK)) begin
                        s_next.phase = IMC_PH_REINIT; // [R9]
                        s_next.timer = 32'(REINIT_CYCLES - 1);
                        s_next.rearm = 1'b0;
                    end else begin
                        s_next.phase = IMC_PH_RUN;
                    end
                end
            end
            IMC_PH_REINIT: begin
                // Sampling and data ready are silent; the host waits for them
                if (wr_stb) begin
                    s_next.rearm = 1'b1; // [R15]
                end
                if (s_reg.timer != 32'h0000_0000) begin
                    s_next.timer = s_reg.timer - 32'h0000_0001;
                end else begin
                    s_next.misc_control = (s_reg.misc_control & ~imc_pkg::SLOW_BITS_MASK)
                        | (s_reg.written & imc_pkg::SLOW_BITS_MASK); // [R9]
                    if (s_reg.rearm || wr_stb) begin
                        s_next.phase = IMC_PH_APPLY;
                        s_next.timer = 32'(APPLY_CYCLES - 1);
                    end else begin
                        s_next.phase = IMC_PH_RUN;
                    end
                end
            end
            default: begin
                s_next.phase = IMC_PH_RUN;
            end
        endcase

        // Sample clock source chosen by the shown sync mode
        if ((s_reg.phase == IMC_PH_REINIT) || (s_next.phase == IMC_PH_REINIT)) begin
            s_next.int_cnt = 32'h0000_0000; // [R9]
        end else begin
            unique case (shown_mode)
                imc_pkg::IMC_SYNC_INTERNAL, imc_pkg::IMC_SYNC_OUTPUT: begin
                    if (s_reg.int_cnt >= 32'(INT_SAMPLE_CYCLES - 1)) begin
                        s_next.int_cnt = 32'h0000_0000;
                        tick = 1'b1; // [R11] [R14]
                    end else begin
                        s_next.int_cnt = s_reg.int_cnt + 32'h0000_0001;
                    end
                end
                imc_pkg::IMC_SYNC_DIRECT: begin
                    s_next.int_cnt = 32'h0000_0000;
                    tick = ext_edge; // [R12]
                end
                imc_pkg::IMC_SYNC_SCALED: begin
                    s_next.int_cnt = 32'h0000_0000;
                    tick = scaled_tick; // [R13]
                end
            endcase
        end
        s_next.sample_tick = tick;

        // Pulse timer shared by the data-ready pin and the sync output
        if (s_reg.phase == IMC_PH_REINIT) begin
            s_next.pulse_cnt = 16'h0000;
        end else if (tick) begin
            s_next.pulse_cnt = 16'(imc_pkg::DR_PULSE_CYCLES);
        end else if (s_reg.pulse_cnt != 16'h0000) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 16'h0001;
        end
        active = (s_next.pulse_cnt != 16'h0000);

        // Pin levels follow the polarity bits
        s_next.dr_pin = active ? dr_pol : ~dr_pol; // [R17]
        s_next.sync_oe = (shown_mode == imc_pkg::IMC_SYNC_OUTPUT); // [R14]
        s_next.sync_out = active ? sync_pol : ~sync_pol; // [R16]

        // Burst layout is sampled at a data-ready edge, never mid-cycle
        if (tick) begin
            s_next.burst_wide = s_reg.misc_control[imc_pkg::BIT_BURST_WIDE]; // [R3] [R4]
            s_next.burst_delta = s_reg.misc_control[imc_pkg::BIT_BURST_DELTA]; // [R5] [R4]
        end
    end

    // Single state register
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            s_reg <= '0;
            s_reg.phase <= IMC_PH_RUN;
            s_reg.misc_control <= imc_pkg::MISC_CTRL_RESET;
            s_reg.written <= imc_pkg::MISC_CTRL_RESET;
            s_reg.dr_pin <= ~imc_pkg::MISC_CTRL_RESET[imc_pkg::BIT_DR_POL];
            s_reg.sync_out <= ~imc_pkg::MISC_CTRL_RESET[imc_pkg::BIT_SYNC_POL];
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs taken straight from the state register
    assign O_SYNC = s_reg.sync_out;
    assign O_SYNC_OE = s_reg.sync_oe;
    assign O_SAMPLE_VALID_STROBE = s_reg.dr_pin;
    assign O_SAMPLE_TICK = s_reg.sample_tick;
    assign O_BURST_WIDE_WORDS = s_reg.burst_wide;
    assign O_BURST_DELTA_SEL = s_reg.burst_delta;
    assign O_LIN_ACCEL_COMP_EN = s_reg.misc_control[imc_pkg::BIT_LIN_COMP]; // [R7]
    assign O_POP_ALIGN_EN = s_reg.misc_control[imc_pkg::BIT_POP_ALIGN]; // [R8]
    assign O_SENSOR_BANDWIDTH_SELECT = s_reg.misc_control[imc_pkg::BIT_BANDWIDTH]; // [R10]
    assign O_SENSOR_REINIT = (s_reg.phase == IMC_PH_REINIT);
    assign O_SYNC_MODE = shown_mode;

endmodule : imc_misc_control

// File: verif/imc_misc_control_monitor.sv
// Port-level assertions for the control register bank
`timescale 1ns/100ps
module imc_misc_control_monitor #(
    parameter int INT_SAMPLE_CYCLES = 200,
    parameter int REINIT_CYCLES = 50
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic I_SYNC,
    input wire logic O_SYNC_OE,
    input wire logic O_SAMPLE_TICK,
    input wire logic O_BURST_WIDE_WORDS,
    input wire logic O_BURST_DELTA_SEL,
    input wire logic O_SENSOR_BANDWIDTH_SELECT,
    input wire logic O_SENSOR_REINIT,
    input wire logic [1:0] O_SYNC_MODE
);
    int tick_gap;
    int reinit_len;
    int sync_age;
    logic gap_ok;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);

    // Counters; period check waits for one tick after reinit or external modes
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            tick_gap <= 0;
            reinit_len <= 0;
            sync_age <= 100;
            gap_ok <= 1'b0;
        end else begin
            tick_gap <= O_SAMPLE_TICK ? 1 : tick_gap + 1;
            reinit_len <= O_SENSOR_REINIT ? reinit_len + 1 : 0;
            sync_age <= $changed(I_SYNC) ? 0 : sync_age + 1;
            if (O_SENSOR_REINIT || (O_SYNC_MODE == 2'b01) || (O_SYNC_MODE == 2'b10)) begin
                gap_ok <= 1'b0;
            end else if (O_SAMPLE_TICK) begin
                gap_ok <= 1'b1;
            end
        end
    end

    property p_tick_single;
        O_SAMPLE_TICK |=> !O_SAMPLE_TICK;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("Sample tick wider than one cycle");
    property p_int_period;
        O_SAMPLE_TICK && gap_ok |-> tick_gap == INT_SAMPLE_CYCLES;
    endproperty
    a_int_period: assert property (p_int_period)
        else $error("Internal sample period wrong");
    property p_reinit_quiet;
        O_SENSOR_REINIT |-> !O_SAMPLE_TICK;
    endproperty
    a_reinit_quiet: assert property (p_reinit_quiet)
        else $error("Sample tick during reinit");
    property p_reinit_len;
        $fell(O_SENSOR_REINIT) |-> reinit_len == REINIT_CYCLES;
    endproperty
    a_reinit_len: assert property (p_reinit_len)
        else $error("Reinit length wrong");
    property p_slow_after_reinit;
        $changed(O_SYNC_MODE) || $changed(O_SENSOR_BANDWIDTH_SELECT) |-> $past(O_SENSOR_REINIT);
    endproperty
    a_slow_after_reinit: assert property (p_slow_after_reinit)
        else $error("Mode or bandwidth changed outside reinit");
    property p_wide_on_tick;
        $changed(O_BURST_WIDE_WORDS) |-> O_SAMPLE_TICK || $past(O_SAMPLE_TICK);
    endproperty
    a_wide_on_tick: assert property (p_wide_on_tick)
        else $error("Burst width changed between samples");
    property p_delta_on_tick;
        $changed(O_BURST_DELTA_SEL) |-> O_SAMPLE_TICK || $past(O_SAMPLE_TICK);
    endproperty
    a_delta_on_tick: assert property (p_delta_on_tick)
        else $error("Burst content changed between samples");
    property p_oe_mode;
        $stable(O_SYNC_MODE) && O_SYNC_MODE == $past(O_SYNC_MODE, 2)
            |-> O_SYNC_OE == (O_SYNC_MODE == 2'b11);
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("Sync pin drive does not match mode");
    property p_direct_sync;
        O_SAMPLE_TICK && O_SYNC_MODE == 2'b01 |-> sync_age <= 8;
    endproperty
    a_direct_sync: assert property (p_direct_sync)
        else $error("Direct-mode tick not tied to a sync edge");
endmodule : imc_misc_control_monitor

bind imc_misc_control imc_misc_control_monitor #(
    .INT_SAMPLE_CYCLES(INT_SAMPLE_CYCLES),
    .REINIT_CYCLES(REINIT_CYCLES)
) u_monitor (
    .I_REF_CLK(I_REF_CLK),
    .I_RESET(I_RESET),
    .I_SYNC(I_SYNC),
    .O_SYNC_OE(O_SYNC_OE),
    .O_SAMPLE_TICK(O_SAMPLE_TICK),
    .O_BURST_WIDE_WORDS(O_BURST_WIDE_WORDS),
    .O_BURST_DELTA_SEL(O_BURST_DELTA_SEL),
    .O_SENSOR_BANDWIDTH_SELECT(O_SENSOR_BANDWIDTH_SELECT),
    .O_SENSOR_REINIT(O_SENSOR_REINIT),
    .O_SYNC_MODE(O_SYNC_MODE)
);

// File: verif/imc_host_model.sv
// Host controller model for the serial register port
`timescale 1ns/100ps
module imc_host_model (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    // Idle: clock high, frame deselected
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // One 16-bit frame, MSB first; four clocks a phase keeps it slow enough
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (int i = 15; i >= 0; i--) begin
            o_sclk <= 1'b0;
            o_mosi <= tx[i];
            repeat (4) @(posedge i_clk);
            rx[i] = i_miso;
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
        o_cs_n <= 1'b1;
        o_mosi <= ~tx[0]; // No stale bit left on a released line
        repeat (4) @(posedge i_clk);
    endtask : xfer
endmodule : imc_host_model

// File: verif/test_imc_misc_control.sv
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module test_imc_misc_control;
    // Row: low byte, high byte, expected control word
    localparam logic [31:0] ROWS [4] = '{32'h0000_0000, 32'hC3FF_03C3, 32'h8001_0180,
        32'h4102_0241};
    logic clk, rst, sclk, cs_n, mosi, miso, tb_sync, sync_o, sync_oe, strobe, tick;
    logic wide, delta, lin, pop, bw, reinit;
    logic [1:0] mode;
    logic [15:0] rd;
    int num_errors = 0;
    int tests_run = 0;
    int tick_cnt = 0;
    int cycles = 0;
    int c0;
    wire logic sync_pin;

    // Shared sync pin: device output wins while it drives
    assign sync_pin = sync_oe ? sync_o : tb_sync;

    imc_misc_control #(.APPLY_CYCLES(20), .REINIT_CYCLES(50), .INT_SAMPLE_CYCLES(200),
        .UPSCALE_FACTOR(16'h0004), .GYRO_RANGE_CODE(2'h0)) DUT (
        .I_REF_CLK(clk), .I_RESET(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_MOSI(mosi),
        .I_SYNC(sync_pin), .O_MISO(miso), .O_SYNC(sync_o), .O_SYNC_OE(sync_oe),
        .O_SAMPLE_VALID_STROBE(strobe), .O_SAMPLE_TICK(tick), .O_BURST_WIDE_WORDS(wide),
        .O_BURST_DELTA_SEL(delta), .O_LIN_ACCEL_COMP_EN(lin), .O_POP_ALIGN_EN(pop),
        .O_SENSOR_BANDWIDTH_SELECT(bw), .O_SENSOR_REINIT(reinit), .O_SYNC_MODE(mode));
    imc_host_model host (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Tick tally and run ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (tick === 1'b1) begin
            tick_cnt <= tick_cnt + 1;
        end
        if (cycles == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] x;
        host.xfer({1'b1, a, d}, x);
    endtask : wr

    // A read answers in the following frame
    task automatic rdw(input logic [6:0] a, output logic [15:0] d);
        logic [15:0] x;
        host.xfer({1'b0, a, 8'h00}, x);
        host.xfer({1'b0, a, 8'h00}, d);
    endtask : rdw

    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 500);
        chk1(tick, 1'b1);
    endtask : wait_tick

    // Slow bits: host waits out the reinit before reading back
    task automatic set_lo(input logic [7:0] lo);
        int n;
        wr(7'h60, lo);
        n = 0;
        while (reinit !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk1(reinit, 1'b1);
        while (reinit !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk1(reinit, 1'b0);
        rdw(7'h60, rd);
        chk16(rd, {8'h02, lo});
        chk16({14'h0000, mode}, {14'h0000, lo[3:2]});
        chk1(bw, lo[4]);
    endtask : set_lo

    initial begin
        rst = 1'b1;
        tb_sync = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk16({lin, pop, bw, sync_oe, strobe, sync_o, reinit, wide, delta, mode, 5'h00},
            16'hC400);
        rdw(7'h60, rd);
        chk16(rd, 16'h00C1);
        rdw(7'h5E, rd);
        chk16(rd, 16'h0003);
        rdw(7'h70, rd);
        chk16(rd, 16'h0000);
        foreach (ROWS[i]) begin
            wr(7'h60, ROWS[i][31:24]);
            wr(7'h61, ROWS[i][23:16]);
            rdw(7'h60, rd);
            chk16(rd, ROWS[i][15:0]);
            chk1(lin, ROWS[i][7]);
            chk1(pop, ROWS[i][6]);
            wait_tick();
            chk1(strobe, ROWS[i][0]);
            @(negedge clk);
            chk1(wide, ROWS[i][9]);
            chk1(delta, ROWS[i][8]);
            repeat (150) @(negedge clk);
            chk1(strobe, ~ROWS[i][0]);
        end
        // Unmapped write must leave the control word alone
        wr(7'h70, 8'hFF);
        rdw(7'h60, rd);
        chk16(rd, 16'h0241);
        set_lo(8'hD1);
        // Direct mode on rising sync edges only
        set_lo(8'hD7);
        @(negedge clk);
        c0 = tick_cnt;
        repeat (3) begin
            @(posedge clk);
            tb_sync <= 1'b0;
            repeat (150) @(posedge clk);
            tb_sync <= 1'b1;
            repeat (150) @(posedge clk);
        end
        @(negedge clk);
        chk16(16'(tick_cnt - c0), 16'h0003);
        // Scaled mode: four ticks in each sync period once measured
        set_lo(8'hD9);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            tb_sync <= 1'b0;
            repeat (50) @(negedge clk);
            if (i == 3) begin
                c0 = tick_cnt;
            end
            if (i == 4) begin
                chk16(16'(tick_cnt - c0), 16'h0004);
            end
            repeat (350) @(posedge clk);
            tb_sync <= 1'b1;
            repeat (400) @(posedge clk);
        end
        // Output mode: device drives sync, falling polarity means active low
        set_lo(8'hDD);
        chk1(sync_oe, 1'b1);
        wait_tick();
        chk1(sync_o, 1'b0);
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdw(7'h60, rd);
        chk16(rd, 16'h00C1);
        chk1(sync_oe, 1'b0);
        stop_test();
    end
endmodule : test_imc_misc_control
